// file: design/ufm_device_end.sv
// Device end: message sender, ordinary data buffer and message receiver.
`timescale 1ns/1ns
// Summary of operation
// - Length code n means 2*(n+1) bytes.
// - User holds request and length until grant.
// - Grant only when ready to send message.
// - Payload starts cycle after the grant cycle.
// - Transmit ready low during message payload.
// - Beats equal bytes over port width, rounded up.
// - Request only with whole payload available.
// - Granted message runs without pause or gaps.
// - Single-beat message blocks ready two cycles.
// - Header in grant cycle, then payload beats.
// - Received payload on own stream port.
// - Byte mask on final beat shows bytes.
// - One-beat message: present and final together.
// - Multi-beat: final and mask on last.
// - Messages take priority over ordinary data.
module ufm_device_end #(
    parameter int BYTES = ufm_pkg::BYTES_DEF,
    parameter int DEPTH = ufm_pkg::FIFO_DEPTH,
    localparam int W    = 8 * BYTES,
    localparam int PW   = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    // Clock and reset.
    input  wire logic               clock,
    input  wire logic               sys_rst,
    // Link to the user end.
    ufm_link_if.dev_mp              lnk,
    // Channel transmit side; ordinary data and message starts wait for open, beats of a started message do not.
    input  wire logic               ch_tx_open,
    output logic [W-1:0]            ch_tx_word,
    output logic                    ch_tx_valid,
    output ufm_pkg::ufm_kind_t      ch_tx_kind,
    // Channel receive side.
    input  wire logic [W-1:0]       ch_rx_word,
    input  wire logic               ch_rx_valid,
    input  wire ufm_pkg::ufm_kind_t ch_rx_kind
);

    // ****************************************************************
    // Transmit sequencer
    // ****************************************************************
    ufm_pkg::ufm_state_t       state_q, state_d;
    logic [ufm_pkg::LEN_W-1:0] code_q;
    logic [ufm_pkg::CNT_W-1:0] left_q, left_d;
    logic                      grant_q, tx_ready_q;
    logic [W-1:0]              word_q, word_d;
    logic                      wvalid_q, wvalid_d;
    ufm_pkg::ufm_kind_t        kind_q, kind_d;

    // Ordinary data buffer.
    logic [W-1:0]              fifo_q [DEPTH];
    logic [PW-1:0]             wr_q, rd_q;
    logic [PW:0]               cnt_q, cnt_d;

    // Decode of the sequencer and buffer events.
    wire in_msg   = (state_q != ufm_pkg::ST_IDLE);
    wire start    = (state_q == ufm_pkg::ST_IDLE) && !grant_q
                    && lnk.msg_send_request && ch_tx_open;
    wire pay_last = (state_q == ufm_pkg::ST_PAY) && (left_q == 1);
    wire push     = lnk.tx_valid && tx_ready_q;
    wire pop      = !in_msg && (cnt_q != 0) && ch_tx_open;
    wire [PW-1:0] wr_nx = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    wire [PW-1:0] rd_nx = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;

    // Next state of the sequencer and the channel word.
    always_comb begin
        state_d  = state_q;
        left_d   = left_q;
        word_d   = fifo_q[rd_q];
        wvalid_d = pop;
        kind_d   = ufm_pkg::KIND_DATA;
        case (state_q)
            ufm_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = ufm_pkg::ST_HDR;
                    left_d  = ufm_pkg::msg_beats(lnk.msg_length_select,
                                                 BYTES);
                end
            end
            ufm_pkg::ST_HDR: begin
                // The header goes out in the grant cycle.
                word_d   = W'(code_q);
                wvalid_d = 1'b1;
                kind_d   = ufm_pkg::KIND_HDR;
                state_d  = ufm_pkg::ST_PAY;
            end
            ufm_pkg::ST_PAY: begin
                // Every cycle takes one beat; no pause is possible.
                word_d   = lnk.tx_data;
                wvalid_d = 1'b1;
                kind_d   = ufm_pkg::KIND_MSG;
                left_d   = left_q - 1'b1;
                if (pay_last) begin
                    state_d = ufm_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = ufm_pkg::ST_IDLE;
            end
        endcase
    end

    // Buffer occupancy after this edge.
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Registered ready only promises room that already exists.
    wire ready_d = (state_d == ufm_pkg::ST_IDLE)
                   && (cnt_d != (PW + 1)'(DEPTH));

    // Sequencer registers.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q    <= ufm_pkg::ST_IDLE;
            left_q     <= '0;
            code_q     <= '0;
            grant_q    <= ufm_pkg::GRANT_RST;
            tx_ready_q <= ufm_pkg::READY_RST;
        end else begin
            state_q    <= state_d;
            left_q     <= left_d;
            grant_q    <= start;
            tx_ready_q <= ready_d;
            if (start) begin
                code_q <= lnk.msg_length_select;
            end
        end
    end

    // Buffer pointers and count; storage needs no reset.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            if (push) begin
                wr_q <= wr_nx;
            end
            if (pop) begin
                rd_q <= rd_nx;
            end
        end
    end

    // Buffer storage.
    always_ff @(posedge clock) begin
        if (push) begin
            fifo_q[wr_q] <= lnk.tx_data;
        end
    end

    // Channel word register.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            word_q   <= '0;
            wvalid_q <= 1'b0;
            kind_q   <= ufm_pkg::KIND_DATA;
        end else begin
            word_q   <= word_d;
            wvalid_q <= wvalid_d;
            kind_q   <= kind_d;
        end
    end

    // ****************************************************************
    // Receive side
    // ****************************************************************
    logic [ufm_pkg::CNT_W-1:0] rx_left_q;
    logic [ufm_pkg::LEN_W-1:0] rx_code_q;
    logic [W-1:0]              rx_data_q;
    logic                      rx_present_q, rx_final_q;
    logic [BYTES-1:0]          rx_mask_q, last_mask;

    // Payload beats count only inside a header's length.
    wire rx_hdr  = ch_rx_valid && (ch_rx_kind == ufm_pkg::KIND_HDR);
    wire rx_beat = ch_rx_valid && (ch_rx_kind == ufm_pkg::KIND_MSG)
                   && (rx_left_q != 0);
    wire rx_last = (rx_left_q == 1);
    wire [ufm_pkg::LEN_W-1:0] hdr_code = ch_rx_word[ufm_pkg::LEN_W-1:0];
    wire [31:0] rx_rem = ufm_pkg::last_bytes(rx_code_q, BYTES);

    // Valid bytes sit at the top of the final beat.
    for (genvar i = 0; i < BYTES; i++) begin : g_mask
        assign last_mask[i] = (i >= int'(BYTES - rx_rem));
    end

    // Receive registers; no stall, each beat goes out at once.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_left_q    <= '0;
            rx_code_q    <= '0;
            rx_data_q    <= '0;
            rx_present_q <= 1'b0;
            rx_final_q   <= 1'b0;
            rx_mask_q    <= '0;
        end else begin
            rx_present_q <= rx_beat;
            if (rx_hdr) begin
                rx_code_q <= hdr_code;
                rx_left_q <= ufm_pkg::msg_beats(hdr_code, BYTES);
            end else if (rx_beat) begin
                rx_left_q  <= rx_left_q - 1'b1;
                rx_data_q  <= ch_rx_word;
                rx_final_q <= rx_last;
                rx_mask_q  <= rx_last ? last_mask : '1;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign lnk.tx_ready         = tx_ready_q;
    assign lnk.msg_send_grant   = grant_q;
    assign lnk.msg_rx_payload   = rx_data_q;
    assign lnk.msg_rx_present   = rx_present_q;
    assign lnk.msg_rx_final     = rx_final_q;
    assign lnk.msg_rx_byte_mask = rx_mask_q;
    assign ch_tx_word           = word_q;
    assign ch_tx_valid          = wvalid_q;
    assign ch_tx_kind           = kind_q;

endmodule : ufm_device_end

// file: design/ufm_pkg.sv
// Shared constants, types and helpers for the in-band control message ports.
package ufm_pkg;

    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    // Default data port width in bytes.
    localparam int unsigned BYTES_DEF     = 4;
    // Largest message in bytes, and the width of its length code.
    localparam int unsigned MSG_MAX_BYTES = 16;
    localparam int unsigned LEN_W         = 3;
    // Entries in the ordinary data buffer of the device end.
    localparam int unsigned FIFO_DEPTH    = 2;
    // Beat counters hold up to fifteen beats.
    localparam int unsigned CNT_W         = 4;
    // Reset values of the handshake flags.
    localparam logic        READY_RST     = 1'b0;
    localparam logic        GRANT_RST     = 1'b0;

    // ****************************************************************
    // Types
    // ****************************************************************
    // What a channel word carries.
    typedef enum logic [1:0] {
        KIND_DATA = 2'b00,
        KIND_HDR  = 2'b01,
        KIND_MSG  = 2'b10
    } ufm_kind_t;

    // Message sequencer states, shared by both ends.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR  = 2'b01,
        ST_PAY  = 2'b10
    } ufm_state_t;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Byte count of a message: code n gives 2*(n+1) bytes.
    function automatic int unsigned msg_bytes(logic [LEN_W-1:0] code);
        return 2 * (int'(code) + 1);
    endfunction : msg_bytes

    // Beats on a port of the given width, rounded up.
    function automatic logic [CNT_W-1:0] msg_beats(logic [LEN_W-1:0] code,
                                                  int unsigned bytes);
        int unsigned n;
        n = (msg_bytes(code) + bytes - 1) / bytes;
        return n[CNT_W-1:0];
    endfunction : msg_beats

    // Bytes that remain valid on the final beat.
    function automatic int unsigned last_bytes(logic [LEN_W-1:0] code,
                                               int unsigned bytes);
        int unsigned n;
        n = (msg_bytes(code) + bytes - 1) / bytes;
        return msg_bytes(code) - (n - 1) * bytes;
    endfunction : last_bytes

endpackage : ufm_pkg

// file: design/ufm_link_if.sv
// Interface joining the device end and the user end of the message ports.
`timescale 1ns/1ns
interface ufm_link_if #(
    parameter int BYTES = ufm_pkg::BYTES_DEF
);
    localparam int W = 8 * BYTES;

    // Shared transmit data port and its ordinary handshake.
    logic [W-1:0]               tx_data;
    logic                       tx_valid;
    logic                       tx_ready;
    // Message send handshake.
    logic                       msg_send_request;
    logic [ufm_pkg::LEN_W-1:0]  msg_length_select;
    logic                       msg_send_grant;
    // Message receive stream.
    logic [W-1:0]               msg_rx_payload;
    logic                       msg_rx_present;
    logic                       msg_rx_final;
    logic [BYTES-1:0]           msg_rx_byte_mask;

    modport dev_mp (
        input  tx_data, tx_valid, msg_send_request, msg_length_select,
        output tx_ready, msg_send_grant, msg_rx_payload, msg_rx_present,
        output msg_rx_final, msg_rx_byte_mask
    );

    modport usr_mp (
        output tx_data, tx_valid, msg_send_request, msg_length_select,
        input  tx_ready, msg_send_grant, msg_rx_payload, msg_rx_present,
        input  msg_rx_final, msg_rx_byte_mask
    );
endinterface : ufm_link_if

// file: design/ufm_user_end.sv
// User end: drives ordinary data and messages, and captures received ones.
`timescale 1ns/1ns
module ufm_user_end #(
    parameter int BYTES = ufm_pkg::BYTES_DEF,
    localparam int W    = 8 * BYTES,
    localparam int MW   = 8 * ufm_pkg::MSG_MAX_BYTES
) (
    // Clock and reset.
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    // Link to the device end.
    ufm_link_if.usr_mp                     lnk,
    // Ordinary data from the application.
    input  wire logic [W-1:0]              app_data,
    input  wire logic                      app_valid,
    output logic                           app_ready,
    // Message start; the whole payload is given with the pulse.
    input  wire logic                      msg_go,
    input  wire logic [ufm_pkg::LEN_W-1:0] msg_code,
    input  wire logic [MW-1:0]             msg_payload,
    output logic                           msg_busy,
    // Received message beats.
    output logic [W-1:0]                   app_msg_data,
    output logic                           app_msg_valid,
    output logic                           app_msg_last,
    output logic [BYTES-1:0]               app_msg_mask
);

    // ****************************************************************
    // Transmit
    // ****************************************************************
    ufm_pkg::ufm_state_t       st_q;
    logic [ufm_pkg::LEN_W-1:0] code_q;
    logic [ufm_pkg::CNT_W-1:0] left_q;
    logic [MW-1:0]             pay_q;
    logic                      req_q, ord_full_q, app_ready_q;
    logic                      tx_valid_q;
    logic [W-1:0]              ord_q, tx_data_q;

    // Decode; payload beats leave from the low end of the shifter.
    wire go_ok   = msg_go && (st_q == ufm_pkg::ST_IDLE);
    wire granted = (st_q == ufm_pkg::ST_HDR) && lnk.msg_send_grant;
    wire sending = (st_q == ufm_pkg::ST_PAY) && (left_q > 1);
    wire sent    = lnk.tx_valid && lnk.tx_ready;
    wire take    = app_valid && app_ready_q;
    wire ord_full_d = take || (ord_full_q && !sent);
    wire [W-1:0] ord_d = take ? app_data : ord_q;
    wire msg_next = granted || sending;

    // Request, sequencing and payload shifter.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q   <= ufm_pkg::ST_IDLE;
            req_q  <= 1'b0;
            code_q <= '0;
            left_q <= '0;
            pay_q  <= '0;
        end else begin
            if (go_ok) begin
                st_q   <= ufm_pkg::ST_HDR;
                req_q  <= 1'b1;
                code_q <= msg_code;
                pay_q  <= msg_payload;
            end else if (granted) begin
                st_q   <= ufm_pkg::ST_PAY;
                req_q  <= 1'b0;
                left_q <= ufm_pkg::msg_beats(code_q, BYTES);
                pay_q  <= pay_q >> W;
            end else if (st_q == ufm_pkg::ST_PAY) begin
                left_q <= left_q - 1'b1;
                pay_q  <= pay_q >> W;
                if (left_q <= 1) begin
                    st_q <= ufm_pkg::ST_IDLE;
                end
            end
        end
    end

    // Shared port: message beats back to back, else ordinary data.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ord_q       <= '0;
            ord_full_q  <= 1'b0;
            app_ready_q <= 1'b0;
            tx_valid_q  <= 1'b0;
            tx_data_q   <= '0;
        end else begin
            ord_q       <= ord_d;
            ord_full_q  <= ord_full_d;
            app_ready_q <= !ord_full_d;
            tx_valid_q  <= ord_full_d && !msg_next;
            tx_data_q   <= msg_next ? pay_q[W-1:0] : ord_d;
        end
    end

    // ****************************************************************
    // Receive: no back-pressure, so each present beat is kept at once.
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            app_msg_data  <= '0;
            app_msg_valid <= 1'b0;
            app_msg_last  <= 1'b0;
            app_msg_mask  <= '0;
        end else begin
            app_msg_valid <= lnk.msg_rx_present;
            if (lnk.msg_rx_present) begin
                app_msg_data <= lnk.msg_rx_payload;
                app_msg_last <= lnk.msg_rx_final;
                app_msg_mask <= lnk.msg_rx_byte_mask;
            end
        end
    end

    // Outputs.
    assign lnk.tx_data           = tx_data_q;
    assign lnk.tx_valid          = tx_valid_q;
    assign lnk.msg_send_request  = req_q;
    assign lnk.msg_length_select = code_q;
    assign app_ready             = app_ready_q;
    assign msg_busy              = (st_q != ufm_pkg::ST_IDLE);

endmodule : ufm_user_end

// file: test/ufm_link_chk.sv
// Concurrent checks on the link between the device and user message ends.
`timescale 1ns/1ns
module ufm_link_chk #(
    parameter int BYTES = 4
) (
    // Clock and reset.
    input wire logic                      clock,
    input wire logic                      sys_rst,
    // Transmit handshakes.
    input wire logic                      tx_valid,
    input wire logic                      tx_ready,
    input wire logic                      msg_send_request,
    input wire logic [ufm_pkg::LEN_W-1:0] msg_length_select,
    input wire logic                      msg_send_grant,
    // Receive stream markers.
    input wire logic                      msg_rx_present,
    input wire logic                      msg_rx_final,
    input wire logic [BYTES-1:0]          msg_rx_byte_mask
);
    // ****************************************************************
    // Payload beat counter
    // ****************************************************************
    logic [4:0] beats_w, cnt_d, cnt_q;

    // Beats owed after a grant, header excluded.
    assign beats_w = 5'((2 * (int'(msg_length_select) + 1) + BYTES - 1)
                        / BYTES);
    assign cnt_d = msg_send_grant ? beats_w :
                   (cnt_q != 5'h00) ? cnt_q - 5'h01 : 5'h00;

    // Reset clears a count left by a cut message.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_grant_pulse: assert property (msg_send_grant |=> !msg_send_grant)
        else $error("grant too long");
    a_grant_after_req: assert property (
        msg_send_grant |-> $past(msg_send_request))
        else $error("grant without request");
    a_ready_at_grant: assert property (msg_send_grant |-> !tx_ready)
        else $error("ready at header");
    a_ready_in_msg: assert property (
        cnt_q != 5'h00 |-> !tx_ready && !tx_valid)
        else $error("data open in message");
    a_grant_spacing: assert property (
        cnt_q != 5'h00 |=> !msg_send_grant)
        else $error("grant inside message");
    a_req_held: assert property (
        msg_send_request && !msg_send_grant |=>
        msg_send_request && $stable(msg_length_select))
        else $error("request dropped early");
    a_mask_partial: assert property (
        msg_rx_present && !msg_rx_final |-> &msg_rx_byte_mask)
        else $error("mask not full mid-message");
    a_mask_final: assert property (
        msg_rx_present && msg_rx_final |-> msg_rx_byte_mask[BYTES-1])
        else $error("top byte unmarked at end");

    // Main scenarios.
    c_long_msg: cover property (msg_send_grant && msg_length_select == 3'h7);
    c_one_beat: cover property (msg_rx_present && msg_rx_final
                                && !$past(msg_rx_present));
    c_multi_beat: cover property (msg_rx_present && !msg_rx_final);
    c_data_taken: cover property (tx_valid && tx_ready);
endmodule : ufm_link_chk

// file: test/tb_top.sv
// Testbench joining both message ends over a loopback.
`timescale 1ns/1ns
module tb_top;
    localparam int BY = 4;
    localparam int W  = 8 * BY;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic                clock       = 1'b0;
    logic                sys_rst     = 1'b1;
    logic [W-1:0]        app_data    = '0;
    logic                app_valid   = 1'b0;
    logic                app_ready;
    logic                msg_go      = 1'b0;
    logic [2:0]          msg_code    = 3'h0;
    logic [127:0]        msg_payload = '0;
    logic [W-1:0]        app_msg_data;
    logic                app_msg_valid;
    logic                app_msg_last;
    logic [BY-1:0]       app_msg_mask;
    logic                ch_tx_open  = 1'b1;
    logic [W-1:0]        ch_word;
    logic                ch_valid;
    ufm_pkg::ufm_kind_t  ch_kind;
    int                  bad_count   = 0;
    int                  n_compared  = 0;
    logic [W+BY:0]       rxq[$];
    logic [W-1:0]        chq[$];
    logic [W-1:0]        expq[$];

    ufm_link_if #(.BYTES(BY)) ufm_link_if_inst ();
    // The channel is looped back.
    ufm_device_end #(.BYTES(BY), .DEPTH(2)) ufm_device_end_inst (
        .clock(clock), .sys_rst(sys_rst), .lnk(ufm_link_if_inst),
        .ch_tx_open(ch_tx_open), .ch_tx_word(ch_word),
        .ch_tx_valid(ch_valid), .ch_tx_kind(ch_kind),
        .ch_rx_word(ch_word), .ch_rx_valid(ch_valid),
        .ch_rx_kind(ch_kind));
    ufm_user_end #(.BYTES(BY)) ufm_user_end_inst (
        .clock(clock), .sys_rst(sys_rst), .lnk(ufm_link_if_inst),
        .app_data(app_data), .app_valid(app_valid),
        .app_ready(app_ready), .msg_go(msg_go), .msg_code(msg_code),
        .msg_payload(msg_payload), .msg_busy(),
        .app_msg_data(app_msg_data), .app_msg_valid(app_msg_valid),
        .app_msg_last(app_msg_last), .app_msg_mask(app_msg_mask));
    ufm_link_chk #(.BYTES(BY)) ufm_link_chk_inst (
        .clock(clock), .sys_rst(sys_rst),
        .tx_valid(ufm_link_if_inst.tx_valid),
        .tx_ready(ufm_link_if_inst.tx_ready),
        .msg_send_request(ufm_link_if_inst.msg_send_request),
        .msg_length_select(ufm_link_if_inst.msg_length_select),
        .msg_send_grant(ufm_link_if_inst.msg_send_grant),
        .msg_rx_present(ufm_link_if_inst.msg_rx_present),
        .msg_rx_final(ufm_link_if_inst.msg_rx_final),
        .msg_rx_byte_mask(ufm_link_if_inst.msg_rx_byte_mask));

    always #5 clock = ~clock;

    // Monitors sample at the falling edge, once outputs settle.
    always @(negedge clock) begin
        if (app_msg_valid === 1'b1) begin
            rxq.push_back({app_msg_last, app_msg_mask, app_msg_data});
        end
        if (ch_valid === 1'b1 && ch_kind === ufm_pkg::KIND_DATA) begin
            chq.push_back(ch_word);
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [63:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen,
                     exp);
        end
    endtask : check

    // A hang counts as a mismatch and ends the run.
    task automatic hung(input int n, lim);
        if (n >= lim) begin
            bad_count++;
            give_verdict();
        end
    endtask : hung

    // Offers words; each is taken at an edge with ready high.
    task automatic push_words(input int n, input logic [W-1:0] base);
        int t;
        for (int i = 0; i < n; i++) begin
            app_valid <= 1'b1;
            app_data <= base + W'(i);
            expq.push_back(base + W'(i));
            t = 0;
            do begin
                @(posedge clock);
                t++;
                hung(t, 300);
            end while (app_ready !== 1'b1);
        end
        app_valid <= 1'b0;
    endtask : push_words

    task automatic drain_check();
        int n;
        for (n = 1; chq.size() < expq.size(); n++) begin
            @(negedge clock);
            hung(n, 300);
        end
        repeat (4) @(negedge clock);
        check(chq.size(), expq.size());
        foreach (expq[i]) check(chq[i], expq[i]);
        chq.delete();
        expq.delete();
    endtask : drain_check

    // Sends one message and judges link and loopback.
    task automatic send_msg(input logic [2:0] code, input logic [127:0] pl,
                            input bit busy_data);
        int nb, lb, n;
        logic [BY-1:0] m;
        nb = (2 * (int'(code) + 1) + BY - 1) / BY;
        lb = 2 * (int'(code) + 1) - (nb - 1) * BY;
        m = {BY{1'b1}} << (BY - lb);
        rxq.delete();
        @(posedge clock);
        msg_go <= 1'b1;
        msg_code <= code;
        msg_payload <= pl;
        @(posedge clock);
        msg_go <= 1'b0;
        for (n = 1; ufm_link_if_inst.msg_send_grant !== 1'b1; n++) begin
            @(negedge clock);
            hung(n, 100);
        end
        check(ufm_link_if_inst.msg_length_select, code);
        check(ufm_link_if_inst.tx_ready, 1'b0);
        for (int k = 0; k < nb; k++) begin
            @(negedge clock);
            check(ufm_link_if_inst.tx_data, pl[k*W +: W]);
            check(ufm_link_if_inst.tx_ready, 1'b0);
        end
        @(negedge clock);
        if (!busy_data) check(ufm_link_if_inst.tx_ready, 1'b1);
        for (n = 1; rxq.size() < nb; n++) begin
            @(negedge clock);
            hung(n, 100);
        end
        repeat (3) @(negedge clock);
        check(rxq.size(), nb);
        for (int k = 0; k < nb; k++) begin
            check(rxq[k], {k == nb - 1, (k == nb - 1) ? m : {BY{1'b1}},
                  pl[k*W +: W]});
        end
        // Later scenarios expect no message beats left behind.
        rxq.delete();
    endtask : send_msg

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        int n;
        repeat (9) @(negedge clock);
        check(ufm_link_if_inst.tx_ready, 1'b0);
        check(ufm_link_if_inst.msg_send_grant, 1'b0);
        check(app_msg_valid, 1'b0);
        @(posedge clock);
        sys_rst <= 1'b0;
        for (n = 1; ufm_link_if_inst.tx_ready !== 1'b1; n++) begin
            @(negedge clock);
            hung(n, 10);
        end
        $display("test reset done");
    endtask : t_reset

    // Every length code once, beats tagged with code and index.
    task automatic t_all_codes();
        logic [127:0] pl;
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 4; k++) begin
                pl[k*W +: W] = 32'hC3A50000 | W'(c << 8) | W'(k);
            end
            send_msg(3'(c), pl, 1'b0);
        end
        $display("test all codes done");
    endtask : t_all_codes

    // Closed channel: the buffer fills, then drains in order.
    task automatic t_stall_fill();
        @(posedge clock);
        ch_tx_open <= 1'b0;
        fork
            push_words(4, 32'h00001000);
        join_none
        repeat (30) @(negedge clock);
        check(ufm_link_if_inst.tx_ready, 1'b0);
        check(chq.size(), 0);
        @(posedge clock);
        ch_tx_open <= 1'b1;
        wait fork;
        drain_check();
        check(rxq.size(), 0);
        $display("test stall fill done");
    endtask : t_stall_fill

    // A message cuts into running data; no word is lost.
    task automatic t_msg_mid_data();
        @(posedge clock);
        fork
            push_words(5, 32'h00002000);
        join_none
        repeat (3) @(posedge clock);
        send_msg(3'h3, {4{32'h5AF00F5A}}, 1'b1);
        wait fork;
        drain_check();
        $display("test mid data done");
    endtask : t_msg_mid_data

    initial begin
        t_reset();
        t_all_codes();
        t_stall_fill();
        t_msg_mid_data();
        give_verdict();
    end
endmodule : tb_top
